// ===== src/dual_edge_gpio_logic.sv
// per-pin gpio logic between core fabric and one bidirectional pad, apb configured
// assumes pad input is asynchronous; core data and apb share i_clk
//
// Overview of operation
// - pad-to-core bit0 is pad input; in dual-edge, bit0 rising sample, bit1 falling
// - core-to-pad bit0 drives pad; in dual-edge, bit0 rising, bit1 falling
// - without input register or dual-edge input, pad value appears on the bypass output
// - core output enable gates the driver, optionally through a register
// - output and enable registers run on the launch clock
// - input registers run on the separate capture clock
// - dual-edge input samples both capture edges into a two-bit word
// - normal dual-edge moves each bit on its own edge, no retiming
// - resync dual-edge exchanges both bits with core on rising edge only
// - resync input delays the falling sample half a period, joins rising bit
// - differential-pair pins used single-ended never run dual-edge
// - bypass path never uses the input register, only the pad synchroniser and one i_clk flop
// - output register offers inversion toward the pad
// - input, output and enable registers each select rising or falling edge of their clock
// - input and output register choices are independent
module dual_edge_gpio_logic
  import dual_edge_gpio_pkg::*;
#(
  parameter bit DIFF_PAIR_PIN = 1'b0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // core fabric
  input wire logic [1:0] i_core_out,
  input wire logic i_core_oe,
  output logic [1:0] o_core_in,
  output logic o_bypass_input,
  // pad
  input wire logic i_pad,
  output logic o_pad,
  output logic o_pad_oe
);

  tick_if cap ();
  tick_if lau ();

  logic pad_m_q, pad_s_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [HALF_W-1:0] cap_half_q, lau_half_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, rdata;
  logic acc, wr_fire, ddr_in_on, ddr_out_on, resync;
  logic in_tick, out_tick, oe_tick;
  logic in0_q, in_hi_q, in_lo_q, rs_hi_q, rs_lo_q;
  logic out0_q, out_hi_q, out_lo_q, oe_q;
  logic [1:0] core_in_q, core_in_d;
  logic bypass_q, pad_q, pad_oe_q, pad_d, oe_d;

  function automatic logic pick_edge(input logic fall_sel, input logic rise,
                                     input logic fall);
    return fall_sel ? fall : rise;
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
    return (addr == CTRL_OFS) || (addr == DIV_OFS) || (addr == STAT_OFS);
  endfunction

  // ==========================================================================
  // capture and launch clocks
  edge_tick_gen u_cap_gen (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_half(cap_half_q),
    .o_tick(cap)
  );

  edge_tick_gen u_lau_gen (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_half(lau_half_q),
    .o_tick(lau)
  );

  // ==========================================================================
  // pad synchroniser
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pad_m_q <= 1'b0;
      pad_s_q <= 1'b0;
    end else begin
      pad_m_q <= i_pad;
      pad_s_q <= pad_m_q;
    end
  end

  // ==========================================================================
  // apb slave, one wait state
  assign acc = i_psel & i_penable & ~pready_q;
  assign wr_fire = i_psel & i_penable & pready_q & i_pwrite & ~pslverr_q;

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (i_paddr)
      CTRL_OFS: rdata[CTRL_W-1:0] = ctrl_q;
      DIV_OFS: begin
        rdata[CAP_HALF_LSB +: HALF_W] = cap_half_q;
        rdata[LAU_HALF_LSB +: HALF_W] = lau_half_q;
      end
      STAT_OFS: begin
        rdata[ST_CORE_IN_LSB +: 2] = core_in_q;
        rdata[ST_PAD_BIT] = pad_s_q;
        rdata[ST_BYPASS_BIT] = bypass_q;
        rdata[ST_PAD_OE_BIT] = pad_oe_q;
        rdata[ST_CAP_LVL_BIT] = cap.level;
        rdata[ST_LAU_LVL_BIT] = lau.level;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      if (acc) begin
        pslverr_q <= ~addr_hit(i_paddr);
        prdata_q <= i_pwrite ? 32'h0000_0000 : rdata;
      end
    end
  end

  // config registers
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= CTRL_RST;
      cap_half_q <= HALF_RST;
      lau_half_q <= HALF_RST;
    end else if (wr_fire) begin
      if (i_paddr == CTRL_OFS) begin
        ctrl_q <= i_pwdata[CTRL_W-1:0];
        if (DIFF_PAIR_PIN) begin
          ctrl_q[DDR_IN_BIT] <= 1'b0;
          ctrl_q[DDR_OUT_BIT] <= 1'b0;
        end
      end
      if (i_paddr == DIV_OFS) begin
        cap_half_q <= i_pwdata[CAP_HALF_LSB +: HALF_W];
        lau_half_q <= i_pwdata[LAU_HALF_LSB +: HALF_W];
      end
    end
  end

  assign ddr_in_on = ctrl_q[DDR_IN_BIT] & ~DIFF_PAIR_PIN;
  assign ddr_out_on = ctrl_q[DDR_OUT_BIT] & ~DIFF_PAIR_PIN;
  assign resync = ctrl_q[RESYNC_BIT];
  assign in_tick = pick_edge(ctrl_q[IN_FALL_BIT], cap.rise, cap.fall);
  assign out_tick = pick_edge(ctrl_q[OUT_FALL_BIT], lau.rise, lau.fall);
  assign oe_tick = pick_edge(ctrl_q[OE_FALL_BIT], lau.rise, lau.fall);

  // ==========================================================================
  // input path on capture clock
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      in0_q <= 1'b0;
    end else if (in_tick) begin
      in0_q <= pad_s_q;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      in_hi_q <= 1'b0;
      in_lo_q <= 1'b0;
      rs_hi_q <= 1'b0;
      rs_lo_q <= 1'b0;
    end else begin
      if (cap.rise) begin
        in_hi_q <= pad_s_q;
        rs_hi_q <= in_hi_q;
        rs_lo_q <= in_lo_q;
      end
      if (cap.fall) begin
        in_lo_q <= pad_s_q;
      end
    end
  end

  always_comb begin
    if (ddr_in_on) begin
      core_in_d = resync ? {rs_lo_q, rs_hi_q} : {in_lo_q, in_hi_q};
    end else if (ctrl_q[IN_REG_BIT]) begin
      core_in_d = {1'b0, in0_q};
    end else begin
      core_in_d = {1'b0, pad_s_q};
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      core_in_q <= 2'h0;
      bypass_q <= 1'b0;
    end else begin
      core_in_q <= core_in_d;
      bypass_q <= ~ctrl_q[IN_REG_BIT] & ~ddr_in_on & pad_s_q;
    end
  end

  // ==========================================================================
  // output and enable path on launch clock
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out0_q <= 1'b0;
    end else if (out_tick) begin
      out0_q <= i_core_out[0];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      oe_q <= 1'b0;
    end else if (oe_tick) begin
      oe_q <= i_core_oe;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_hi_q <= 1'b0;
      out_lo_q <= 1'b0;
    end else begin
      if (lau.rise) begin
        out_hi_q <= i_core_out[0];
      end
      if (resync ? lau.rise : lau.fall) begin
        out_lo_q <= i_core_out[1];
      end
    end
  end

  // output choice is independent of input choice
  always_comb begin
    if (ddr_out_on) begin
      pad_d = (lau.level ? out_hi_q : out_lo_q) ^ ctrl_q[OUT_INV_BIT];
    end else if (ctrl_q[OUT_REG_BIT]) begin
      pad_d = out0_q ^ ctrl_q[OUT_INV_BIT];
    end else begin
      pad_d = i_core_out[0];
    end
    oe_d = ctrl_q[OE_REG_BIT] ? oe_q : i_core_oe;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pad_q <= 1'b0;
      pad_oe_q <= 1'b0;
    end else begin
      pad_q <= pad_d;
      pad_oe_q <= oe_d;
    end
  end

  assign o_core_in = core_in_q;
  assign o_bypass_input = bypass_q;
  assign o_pad = pad_q;
  assign o_pad_oe = pad_oe_q;
  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence seq_oe_cap;
    ctrl_q[OE_REG_BIT] && oe_tick ##1 ctrl_q[OE_REG_BIT];
  endsequence
  sequence seq_in_cap;
    ctrl_q[IN_REG_BIT] && !ddr_in_on && in_tick ##1 ctrl_q[IN_REG_BIT] && !ddr_in_on;
  endsequence
  sequence seq_lo_cap;
    ddr_in_on && !resync && cap.fall ##1 ddr_in_on && !resync;
  endsequence

  chk_bypass_pad_follow: assert property (
    $past(!ctrl_q[IN_REG_BIT] && !ddr_in_on) |-> o_bypass_input == $past(i_pad, 3))
    else $error("bypass output does not follow pad");
  chk_bypass_reg_off: assert property (
    $past(ctrl_q[IN_REG_BIT]) |-> !o_bypass_input)
    else $error("bypass active while input registered");
  chk_oe_direct: assert property (
    $past(!ctrl_q[OE_REG_BIT]) |-> o_pad_oe == $past(i_core_oe))
    else $error("unregistered enable does not pass through");
  chk_oe_launch_reg: assert property (
    seq_oe_cap |=> o_pad_oe == $past(i_core_oe, 2))
    else $error("registered enable wrong after launch edge");
  chk_in_single_cap: assert property (
    seq_in_cap |=> o_core_in[0] == $past(pad_s_q, 2))
    else $error("single-rate capture wrong");
  chk_ddr_fall_bit: assert property (
    seq_lo_cap |=> o_core_in[1] == $past(pad_s_q, 2))
    else $error("falling-edge sample not on bit 1");
  chk_resync_hold: assert property (
    ddr_in_on && resync && !cap.rise ##1 ddr_in_on && resync |=> $stable(o_core_in))
    else $error("resync word changed without rising edge");
  chk_no_ddr_diff: assert property (
    !DIFF_PAIR_PIN || (!ddr_in_on && !ddr_out_on))
    else $error("dual-edge on differential-pair pin");
  chk_out_inverted: assert property (
    $past(ctrl_q[OUT_REG_BIT] && !ddr_out_on && ctrl_q[OUT_INV_BIT])
      |-> o_pad == !$past(out0_q))
    else $error("output inversion missing");

  chk_ddr_out_phase: assert property (
    $past(ddr_out_on && !ctrl_q[OUT_INV_BIT] && !lau.level) |-> o_pad == $past(out_lo_q))
    else $error("low phase does not show bit 1");

  chk_out_direct: assert property (
    $past(!ctrl_q[OUT_REG_BIT] && !ddr_out_on) |-> o_pad == $past(i_core_out[0]))
    else $error("unregistered output does not pass through");

endmodule

// ===== inc/dual_edge_gpio_pkg.sv
// constants for the dual-edge gpio logic: register map, field positions, reset values
// assumes a 32-bit apb slave with byte addresses, one aligned word per register
package dual_edge_gpio_pkg;

  // ==========================================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] DIV_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h08;

  // ==========================================================================
  // control fields
  localparam int CTRL_W = 10;
  localparam int IN_REG_BIT = 0;
  localparam int OUT_REG_BIT = 1;
  localparam int OE_REG_BIT = 2;
  localparam int OUT_INV_BIT = 3;
  localparam int IN_FALL_BIT = 4;
  localparam int OUT_FALL_BIT = 5;
  localparam int OE_FALL_BIT = 6;
  localparam int DDR_IN_BIT = 7;
  localparam int DDR_OUT_BIT = 8;
  localparam int RESYNC_BIT = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

  // ==========================================================================
  // divider fields: capture half period low, launch half period high
  localparam int HALF_W = 16;
  localparam int CAP_HALF_LSB = 0;
  localparam int LAU_HALF_LSB = 16;
  localparam logic [HALF_W-1:0] HALF_RST = 16'h0003;

  // ==========================================================================
  // status fields
  localparam int ST_CORE_IN_LSB = 0;
  localparam int ST_PAD_BIT = 2;
  localparam int ST_BYPASS_BIT = 3;
  localparam int ST_PAD_OE_BIT = 4;
  localparam int ST_CAP_LVL_BIT = 5;
  localparam int ST_LAU_LVL_BIT = 6;

endpackage

// ===== inc/tick_if.sv
// interface carrying one divided clock as level plus edge pulses
// assumes producer and consumers share i_clk
interface tick_if;
  logic level;
  logic rise;
  logic fall;
  modport gen (output level, output rise, output fall);
  modport use_side (input level, input rise, input fall);
endinterface

// ===== src/edge_tick_gen.sv
// divider making a slow clock as a level with one-cycle rise and fall pulses
// assumes i_half is steady or changes only between toggles
module edge_tick_gen
  import dual_edge_gpio_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // half period minus one, in i_clk cycles
  input wire logic [HALF_W-1:0] i_half,
  // divided clock
  tick_if.gen o_tick
);

  logic [HALF_W-1:0] cnt_q;
  logic lvl_q;
  logic rise_q;
  logic fall_q;

  // ==========================================================================
  // divider
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
      lvl_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (cnt_q >= i_half) begin
      cnt_q <= '0;
      lvl_q <= ~lvl_q;
      rise_q <= ~lvl_q;
      fall_q <= lvl_q;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
  end

  assign o_tick.level = lvl_q;
  assign o_tick.rise = rise_q;
  assign o_tick.fall = fall_q;

endmodule

// ===== verif/core_fabric_model.sv
// core fabric stand-in: drives the core-to-pad word and enable, keeps the last word seen
// assumes it runs on the same i_clk as the gpio logic
module core_fabric_model
  import dual_edge_gpio_pkg::*;
(
  // clock
  input wire logic i_clk,
  // words from the bench
  input wire logic [1:0] i_word,
  input wire logic i_oe,
  // gpio side
  output logic [1:0] o_core_out,
  output logic o_core_oe,
  input wire logic [1:0] i_core_in,
  // last word received
  output logic [1:0] o_last_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // fabric registers, launched on the rising edge
  always_ff @(posedge i_clk) begin
    o_core_out <= i_word;
    o_core_oe <= i_oe;
    o_last_in <= i_core_in;
  end
endmodule

// ===== verif/tb.sv
// testbench for dual_edge_gpio_logic: apb registers, plain, registered and dual-edge paths
// assumes the default divider value 3, so capture and launch periods are 8 cycles
module tb
  import dual_edge_gpio_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // signals
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] word = 2'h0;
  logic oe = 1'b0;
  logic pad = 1'b0;
  logic [1:0] core_out, core_in, last_in;
  logic core_oe, pready, pslverr, bypass, opad, opad_oe;
  logic [31:0] prdata;
  logic [32:0] expq[$];
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 98248;
  int ones;

  dual_edge_gpio_logic #(.DIFF_PAIR_PIN(1'b0)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_core_out(core_out), .i_core_oe(core_oe), .o_core_in(core_in),
    .o_bypass_input(bypass), .i_pad(pad), .o_pad(opad), .o_pad_oe(opad_oe));

  core_fabric_model fabric (.i_clk(i_clk), .i_word(word), .i_oe(oe), .o_core_out(core_out),
    .o_core_oe(core_oe), .i_core_in(core_in), .o_last_in(last_in));

  initial begin
    forever #4 i_clk = ~i_clk;
  end

  // ==========================================================================
  // tasks
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [32:0] exp);
    expq.push_back(exp);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    // only the bench timeout ends a missing answer
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_ctrl(input int c);
    apb(1'b1, CTRL_OFS, 32'(c), 33'h000000000);
  endtask

  task automatic count_ones();
    ones = 0;
    repeat (16) begin
      @(posedge i_clk);
      ones += int'(opad);
    end
  endtask

  // ==========================================================================
  // apb answer monitor and timeout
  always @(posedge i_clk) begin
    if (pready === 1'b1) begin
      if (expq.size() == 0) begin
        n_errors++;
      end else begin
        check({pslverr, prdata}, expq.pop_front());
      end
    end
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0, {1'b0, 22'h0, CTRL_RST});
    apb(1'b0, DIV_OFS, 32'h0, {1'b0, HALF_RST, HALF_RST});
    apb(1'b0, 8'h0C, 32'h0, 33'h100000000);
    apb(1'b1, 8'hF0, 32'hFFFFFFFF, 33'h100000000);
    set_ctrl(32'h3FF);
    apb(1'b0, CTRL_OFS, 32'h0, 33'h0000003FF);
    set_ctrl(0);
    $display("registers done");
    for (int i = 0; i < 2; i++) begin
      set_ctrl((i << IN_REG_BIT) | (i << IN_FALL_BIT));
      repeat (8) begin
        word <= 2'($random(seed));
        oe <= 1'($random(seed));
        pad <= 1'($random(seed));
        repeat (24) @(posedge i_clk);
        check(33'(opad), 33'(word[0]));
        check(33'(opad_oe), 33'(oe));
        check(33'(last_in), {31'h0, 1'b0, pad});
        check(33'(bypass), (i == 0) ? 33'(pad) : 33'h0);
      end
    end
    $display("plain and input register paths done");
    for (int f = 0; f < 2; f++) begin
      set_ctrl((1 << OUT_REG_BIT) | (1 << OE_REG_BIT) | (1 << OUT_INV_BIT) |
               (f << OUT_FALL_BIT) | (f << OE_FALL_BIT));
      repeat (4) begin
        word <= 2'($random(seed));
        oe <= 1'($random(seed));
        repeat (24) @(posedge i_clk);
        check(33'(opad), {32'h0, ~word[0]});
        check(33'(opad_oe), 33'(oe));
      end
    end
    $display("output register done");
    for (int r = 0; r < 2; r++) begin
      set_ctrl((1 << DDR_OUT_BIT) | (r << RESYNC_BIT));
      for (int w = 0; w < 4; w++) begin
        word <= 2'(w);
        repeat (24) @(posedge i_clk);
        count_ones();
        check(33'(ones), 33'(8 * (w & 1) + 8 * (w >> 1)));
      end
      set_ctrl((1 << DDR_IN_BIT) | (r << RESYNC_BIT));
      repeat (4) begin
        pad <= 1'($random(seed));
        repeat (24) @(posedge i_clk);
        check(33'(last_in), {31'h0, pad, pad});
        check(33'(bypass), 33'h000000000);
      end
    end
    $display("dual-edge done");
    results();
  end
endmodule
